// ---- design/dual_clock_fifo_flag_modes.sv ----
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "fifo_flag_consts.svh"
module dual_clock_fifo_flag_modes
  import fifo_flag_pkg::*;
#(
  parameter int DW = 18,
  parameter int MEM_DEPTH = 131072
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic master_reset_n_i,
  input wire logic fallthrough_select_serial_in_i,
  input wire logic flag_timing_select_i,
  input wire logic offset_load_n_i,
  input wire logic offset_select_0_i,
  input wire logic offset_select_1_i,
  input wire logic narrow_ports_i,
  input wire logic write_clock_i,
  input wire logic write_enable_n_i,
  input wire logic [DW-1:0] data_in_i,
  input wire logic read_clock_i,
  input wire logic read_enable_n_i,
  output logic [DW-1:0] data_out_o,
  output logic empty_flag_n_o,
  output logic full_flag_n_o,
  output logic almost_empty_flag_n_o,
  output logic almost_full_flag_n_o,
  output logic half_full_flag_n_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  localparam int CW = $clog2(2 * MEM_DEPTH + 2);
  localparam int PW = $clog2(2 * MEM_DEPTH);
  // Offsets stay wide enough for every default pair, even in a shallow build,
  // so a readback never shows a truncated default
  localparam int OW = (CW > 19) ? CW : 19;
  localparam int XW = OW + 1;
  localparam int NX = DW + 11;
  localparam logic [CW-1:0] DEPTH_WIDE = CW'(MEM_DEPTH);
  localparam logic [CW-1:0] DEPTH_NARROW = CW'(2 * MEM_DEPTH);
  localparam logic [1:0] FT_LAST = 2'(`FT_RD_EDGES - 1);

  // Pins and the two link clocks all enter through the same three stages plus a filter register,
  // so data and enables stay aligned with the edge seen on their clock
  wire logic [NX-1:0] ext = {data_in_i, write_clock_i, read_clock_i, write_enable_n_i,
                             read_enable_n_i, master_reset_n_i, fallthrough_select_serial_in_i,
                             flag_timing_select_i, offset_load_n_i, offset_select_0_i,
                             offset_select_1_i, narrow_ports_i};
  wire logic [NX-1:0] cln;

  genvar gi;
  for (gi = 0; gi < NX; gi++) begin : g_sync
    logic s1_ff, s2_ff, s3_ff, c_ff;
    always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        s3_ff <= 1'b0;
        c_ff <= 1'b0;
      end else begin
        s1_ff <= ext[gi];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff) begin
          c_ff <= s3_ff;
        end
      end
    end
    assign cln[gi] = c_ff;
  end

  wire logic [DW-1:0] din = cln[NX-1:11];
  wire logic wclk_c = cln[10];
  wire logic rclk_c = cln[9];
  wire logic wen_n = cln[8];
  wire logic ren_n = cln[7];
  wire logic mrs_act = !cln[6];
  wire logic [2:0] off_pins = {cln[3], cln[2], cln[1]};

  logic wclk_q_ff, rclk_q_ff;
  timing_mode_t mode_ff;
  flag_timing_t ftim_ff;
  logic narrow_ff;
  logic [OW-1:0] n_ff, m_ff;
  logic [CW-1:0] mem_cnt_ff;
  logic [PW-1:0] wptr_ff, rptr_ff;
  logic out_valid_ff;
  logic [1:0] ft_cnt_ff;
  logic [DW-1:0] dout_ff;
  logic ae_ff, af_ff, hf_ff;
  logic [2:0] rflag_ff;
  logic [1:0] wflag_ff;
  logic [31:0] prdata_ff;
  logic [DW-1:0] mem [2*MEM_DEPTH];

  function automatic logic [OW-1:0] off_default(input logic [2:0] sel);
    logic [31:0] v;
    v = `OFF_LLL;
    unique case (sel)
      3'h0: v = `OFF_LLL;
      3'h1: v = `OFF_LLH;
      3'h2: v = `OFF_LHL;
      3'h3: v = `OFF_LHH;
      3'h4: v = `OFF_HLL;
      3'h5: v = `OFF_HLH;
      3'h6: v = `OFF_HHL;
      3'h7: v = `OFF_HHH;
    endcase
    return OW'(v);
  endfunction

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p, input logic [CW-1:0] d);
    return (CW'(p) == d - CW'(1)) ? '0 : PW'(p + PW'(1));
  endfunction

  wire logic wr_ev = wclk_c && !wclk_q_ff;
  wire logic rd_ev = rclk_c && !rclk_q_ff;
  wire logic fall_through_mode = (mode_ff == MODE_FALL_THROUGH);
  wire logic sync_flags = (ftim_ff == FLAG_SYNC);
  wire logic [CW-1:0] depth_eff = narrow_ff ? DEPTH_NARROW : DEPTH_WIDE;
  wire logic [CW-1:0] margin = fall_through_mode ? CW'(`FT_MARGIN) : CW'(`STD_MARGIN);
  wire logic [CW-1:0] held = CW'(mem_cnt_ff + CW'(out_valid_ff));
  wire logic [CW-1:0] full_thr = CW'(depth_eff + CW'(fall_through_mode));
  wire logic mem_full = (mem_cnt_ff == depth_eff);
  wire logic mem_some = (mem_cnt_ff != '0);
  // Compared one bit wider than the offsets so a large empty offset cannot wrap
  wire logic [XW-1:0] held_x = XW'(held);
  wire logic [XW-1:0] ae_thr = XW'(n_ff) + XW'(margin);
  wire logic [CW-1:0] hf_thr = CW'((depth_eff >> 1) + margin);
  wire logic [XW-1:0] af_thr = XW'(full_thr) - XW'(m_ff);
  wire logic ae_now = (held_x >= ae_thr);
  wire logic hf_now = !(held >= hf_thr);
  wire logic af_now = !(held_x >= af_thr);
  wire logic push = wr_ev && !wen_n && !mem_full && !mrs_act;
  wire logic std_pop = !fall_through_mode && rd_ev && !ren_n && mem_some;
  wire logic ft_pop = fall_through_mode && rd_ev && mem_some &&
                      (out_valid_ff ? !ren_n : ft_cnt_ff == FT_LAST);
  wire logic pop = (std_pop || ft_pop) && !mrs_act;
  wire logic ft_drain = fall_through_mode && rd_ev && !ren_n && out_valid_ff && !mem_some && !mrs_act;
  wire logic ft_wait = fall_through_mode && rd_ev && !out_valid_ff && mem_some && !ft_pop;
  wire logic [CW-1:0] nxt_mem_cnt = CW'(mem_cnt_ff + CW'(push) - CW'(pop));
  // Standard pin shows words stored, fall-through pin shows output ready
  wire logic rflag_now = fall_through_mode ? !(mem_some || out_valid_ff) : mem_some;
  wire logic wflag_now = fall_through_mode ? mem_full : !mem_full;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wclk_q_ff <= 1'b0;
      rclk_q_ff <= 1'b0;
    end else begin
      wclk_q_ff <= wclk_c;
      rclk_q_ff <= rclk_c;
    end
  end

  // Configuration is captured only while master reset is held
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_ff <= MODE_STANDARD;
      ftim_ff <= FLAG_ASYNC;
      narrow_ff <= 1'b0;
    end else if (mrs_act) begin
      mode_ff <= cln[5] ? MODE_FALL_THROUGH : MODE_STANDARD;
      ftim_ff <= cln[4] ? FLAG_SYNC : FLAG_ASYNC;
      narrow_ff <= cln[0];
    end
  end

  wire logic apb_acc = psel_i && penable_i;
  wire logic sel_status = (paddr_i == `REG_STATUS);
  wire logic sel_level = (paddr_i == `REG_LEVEL);
  wire logic sel_noff = (paddr_i == `REG_EMPTY_OFFSET);
  wire logic sel_moff = (paddr_i == `REG_FULL_OFFSET);
  wire logic mapped = sel_status || sel_level || sel_noff || sel_moff;
  wire logic ro_write = pwrite_i && (sel_status || sel_level);
  wire logic wr_noff = apb_acc && pwrite_i && sel_noff;
  wire logic wr_moff = apb_acc && pwrite_i && sel_moff;
  wire logic [31:0] status_word = 32'(
    (empty_flag_n_o << `ST_EMPTY_PIN) | (full_flag_n_o << `ST_FULL_PIN) |
    (ae_ff << `ST_ALMOST_EMPTY) | (hf_ff << `ST_HALF_FULL) |
    (af_ff << `ST_ALMOST_FULL) | (fall_through_mode << `ST_FALL_THROUGH) |
    (sync_flags << `ST_SYNC_FLAGS) | (narrow_ff << `ST_NARROW) |
    (out_valid_ff << `ST_OUT_VALID));
  wire logic [31:0] rd_mux = sel_status ? status_word :
                             sel_level ? 32'(held) :
                             sel_noff ? 32'(n_ff) :
                             sel_moff ? 32'(m_ff) : 32'h00000000;

  // Master reset loads the default pair; software may retune it later
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      n_ff <= OW'(`OFF_LLL);
      m_ff <= OW'(`OFF_LLL);
    end else if (mrs_act) begin
      n_ff <= off_default(off_pins);
      m_ff <= off_default(off_pins);
    end else begin
      if (wr_noff) begin
        n_ff <= pwdata_i[OW-1:0];
      end
      if (wr_moff) begin
        m_ff <= pwdata_i[OW-1:0];
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_ff <= 32'h00000000;
    end else if (psel_i && !penable_i) begin
      prdata_ff <= rd_mux;
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = 1'b1;
  assign pslverr_o = apb_acc && (!mapped || ro_write);

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wptr_ff] <= din;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      mem_cnt_ff <= '0;
    end else if (mrs_act) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      mem_cnt_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= bump(wptr_ff, depth_eff);
      end
      if (pop) begin
        rptr_ff <= bump(rptr_ff, depth_eff);
      end
      mem_cnt_ff <= nxt_mem_cnt;
    end
  end

  // Read side: pointer and outputs stay put when nothing is readable
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dout_ff <= '0;
      out_valid_ff <= 1'b0;
      ft_cnt_ff <= 2'h0;
    end else if (mrs_act) begin
      dout_ff <= '0;
      out_valid_ff <= 1'b0;
      ft_cnt_ff <= 2'h0;
    end else begin
      if (pop) begin
        dout_ff <= mem[rptr_ff];
      end
      if (ft_pop) begin
        out_valid_ff <= 1'b1;
      end else if (ft_drain) begin
        out_valid_ff <= 1'b0;
      end
      if (ft_pop || !fall_through_mode) begin
        ft_cnt_ff <= 2'h0;
      end else if (ft_wait) begin
        ft_cnt_ff <= 2'(ft_cnt_ff + 2'h1);
      end
    end
  end

  // Pin flags lag by register stages clocked on their own link clock
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rflag_ff <= 3'h0;
      wflag_ff <= 2'h3;
    end else if (mrs_act) begin
      rflag_ff <= cln[5] ? 3'h7 : 3'h0;
      wflag_ff <= cln[5] ? 2'h0 : 2'h3;
    end else begin
      if (rd_ev) begin
        rflag_ff <= {rflag_ff[1:0], rflag_now};
      end
      if (wr_ev) begin
        wflag_ff <= {wflag_ff[0], wflag_now};
      end
    end
  end

  // Asynchronous flag timing follows any change; synchronous makes almost-empty and
  // almost-full wait for the owning clock, trading latency for glitch-free pins;
  // half-full follows every change in both timings
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ae_ff <= 1'b0;
      af_ff <= 1'b1;
      hf_ff <= 1'b1;
    end else if (mrs_act) begin
      ae_ff <= 1'b0;
      af_ff <= 1'b1;
      hf_ff <= 1'b1;
    end else begin
      if (!sync_flags || rd_ev) begin
        ae_ff <= ae_now;
      end
      if (!sync_flags || wr_ev) begin
        af_ff <= af_now;
      end
      hf_ff <= hf_now;
    end
  end

  assign data_out_o = dout_ff;
  assign empty_flag_n_o = fall_through_mode ? rflag_ff[2] : rflag_ff[1];
  assign full_flag_n_o = wflag_ff[1];
  assign almost_empty_flag_n_o = ae_ff;
  assign almost_full_flag_n_o = af_ff;
  assign half_full_flag_n_o = hf_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_mode_latch: assert property (mrs_act |=> fall_through_mode == $past(cln[5]))
    else $error("timing mode not latched at master reset");
  a_offset_default: assert property (mrs_act |=> n_ff == off_default($past(off_pins)))
    else $error("default offset not loaded");
  a_write_taken: assert property (wr_ev && !wen_n && !mem_full && !mrs_act && !pop
                                  |=> mem_cnt_ff == $past(mem_cnt_ff) + CW'(1))
    else $error("enabled write not stored");
  a_full_discard: assert property (wr_ev && mem_full && !mrs_act
                                   |=> wptr_ff == $past(wptr_ff))
    else $error("write while full moved pointer");
  a_empty_ignore: assert property (rd_ev && !ren_n && !mem_some && !fall_through_mode && !mrs_act
                                   |=> $stable(dout_ff) && $stable(rptr_ff))
    else $error("read while empty changed outputs");
  a_fall_three: assert property (fall_through_mode && !mrs_act && rd_ev && !out_valid_ff && mem_some
                                 && ft_cnt_ff == FT_LAST |=> out_valid_ff)
    else $error("first word not presented on third read edge");
  a_half_level: assert property (!mrs_act ##1 !mrs_act |-> hf_ff == !($past(held) >= $past(hf_thr)))
    else $error("half-full flag wrong for level");
  a_af_sync: assert property (sync_flags && !wr_ev && !mrs_act |=> $stable(af_ff))
    else $error("sync almost-full moved without write edge");
  a_ir_full: assert property (fall_through_mode && !mrs_act && wr_ev && held == full_thr
                              |=> wflag_ff[0])
    else $error("input-ready not asserted at full");
  a_ef_stages: assert property (!fall_through_mode && !mrs_act && rd_ev
                                |=> empty_flag_n_o == $past(rflag_ff[0]))
    else $error("empty flag staging broken");
  a_or_stages: assert property (fall_through_mode && !mrs_act && rd_ev
                                |=> empty_flag_n_o == $past(rflag_ff[1]))
    else $error("output-ready staging broken");
  a_ir_stages: assert property (fall_through_mode && !mrs_act && wr_ev
                                |=> full_flag_n_o == $past(wflag_ff[0]))
    else $error("input-ready staging broken");
  a_ft_drain: assert property (fall_through_mode && !mrs_act && rd_ev && !ren_n && out_valid_ff && !mem_some
                               |=> !out_valid_ff && $stable(dout_ff))
    else $error("last word read did not empty output register");
  a_level_bound: assert property (held <= full_thr)
    else $error("held count above capacity");
  a_ae_sync: assert property (sync_flags && !rd_ev && !mrs_act |=> $stable(ae_ff))
    else $error("sync almost-empty moved without read edge");

  c_fall_through: cover property (fall_through_mode && ft_pop && !out_valid_ff);
  c_ft_drain: cover property (ft_drain);
  c_reach_full: cover property (mem_full && wr_ev && !wen_n);
  c_drain_empty: cover property (std_pop && mem_cnt_ff == CW'(1));
  c_apb_write: cover property (wr_noff);
endmodule
`default_nettype wire

// ---- design/fifo_flag_consts.svh ----
// How it works
// - Mode pin latched at master reset selects timing
// - Fall-through first word appears after three read edges
// - Word captured on write edge while enable low
// - Standard empty flag tracks first write, last read
// - Standard almost-empty high from n+1 words
// - Standard half-full low from D/2+1 words
// - Standard almost-full low from D-m words
// - Standard full flag low at D words
// - Read enable ignored while nothing readable
// - Standard empty/full flags pass two stages
// - Fall-through output-ready tracks first write, last read
// - Fall-through almost-empty high from n+2 words
// - Fall-through half-full low from D/2+2 words
// - Fall-through almost-full low from D+1-m words
// - Fall-through input-ready high at D+1 words
// - First read from full reopens writes
// - Output-ready three stages, input-ready two stages
// - Depth doubles when both ports nine bits
// - Default offsets from load and select pins
// - Synchronous flag timing updates almost-empty/almost-full on own clock; half-full every cycle
`ifndef FIFO_FLAG_CONSTS_SVH
`define FIFO_FLAG_CONSTS_SVH

`define REG_STATUS 32'h00000000
`define REG_LEVEL 32'h00000004
`define REG_EMPTY_OFFSET 32'h00000008
`define REG_FULL_OFFSET 32'h0000000C

`define ST_EMPTY_PIN 0
`define ST_FULL_PIN 1
`define ST_ALMOST_EMPTY 2
`define ST_HALF_FULL 3
`define ST_ALMOST_FULL 4
`define ST_FALL_THROUGH 5
`define ST_SYNC_FLAGS 6
`define ST_NARROW 7
`define ST_OUT_VALID 8

`define OFF_LLL 32'h0000007F
`define OFF_LLH 32'h00003FFF
`define OFF_LHL 32'h00001FFF
`define OFF_LHH 32'h00000FFF
`define OFF_HLL 32'h000003FF
`define OFF_HLH 32'h000007FF
`define OFF_HHL 32'h000001FF
`define OFF_HHH 32'h000000FF

`define FT_RD_EDGES 3
`define STD_MARGIN 1
`define FT_MARGIN 2

`endif

// ---- design/fifo_flag_pkg.sv ----
package fifo_flag_pkg;
  typedef enum logic {MODE_STANDARD, MODE_FALL_THROUGH} timing_mode_t;
  typedef enum logic {FLAG_ASYNC, FLAG_SYNC} flag_timing_t;
endpackage

// ---- test/link_partner.sv ----
`timescale 1ns/1ns
`default_nettype none
module link_partner (
  input wire logic clock_i,
  output logic write_clock_o,
  output logic write_enable_n_o,
  output logic [17:0] data_o,
  output logic read_clock_o,
  output logic read_enable_n_o
);
  initial begin
    write_clock_o = 1'b0;
    read_clock_o = 1'b0;
    write_enable_n_o = 1'b1;
    read_enable_n_o = 1'b1;
    data_o = 18'h00000;
  end

  // One link clock period of 8 system cycles; both link clocks rise together
  task automatic cyc(input logic wr, input logic rd, input logic [17:0] d);
    @(posedge clock_i);
    write_clock_o <= 1'b0;
    read_clock_o <= 1'b0;
    write_enable_n_o <= !wr;
    read_enable_n_o <= !rd;
    // Idle data toggles so a stale word can never pass for a fresh one
    data_o <= wr ? d : ~data_o;
    repeat (4) @(posedge clock_i);
    write_clock_o <= 1'b1;
    read_clock_o <= 1'b1;
    repeat (3) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "fifo_flag_consts.svh"
module tb;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic master_reset_n_i = 1'b0;
  logic fallthrough_select_serial_in_i = 1'b0;
  logic flag_timing_select_i = 1'b0;
  logic offset_load_n_i = 1'b0;
  logic offset_select_0_i = 1'b0;
  logic offset_select_1_i = 1'b0;
  logic narrow_ports_i = 1'b0;
  logic write_clock_i, write_enable_n_i, read_clock_i, read_enable_n_i;
  logic [17:0] data_in_i, data_out_o;
  logic empty_flag_n_o, full_flag_n_o, almost_empty_flag_n_o;
  logic almost_full_flag_n_o, half_full_flag_n_o, pready_o, pslverr_o;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, r;
  logic [17:0] q[$];
  logic [17:0] expd, msk;
  logic e, have, ft;
  int dep, n, m, p, err_count, num_checks;
  int seed = 32'h0C3C;
  logic [2:0] pins [3] = '{3'b000, 3'b111, 3'b010};
  logic [31:0] dflt [3] = '{32'h0000007F, 32'h000000FF, 32'h00001FFF};

  dual_clock_fifo_flag_modes #(.DW(18), .MEM_DEPTH(16)) dual_clock_fifo_flag_modes_inst (
    .clock_i, .resetn_i, .master_reset_n_i, .fallthrough_select_serial_in_i,
    .flag_timing_select_i, .offset_load_n_i, .offset_select_0_i, .offset_select_1_i,
    .narrow_ports_i, .write_clock_i, .write_enable_n_i, .data_in_i, .read_clock_i,
    .read_enable_n_i, .data_out_o, .empty_flag_n_o, .full_flag_n_o, .almost_empty_flag_n_o,
    .almost_full_flag_n_o, .half_full_flag_n_o, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o);

  link_partner link_partner_inst (.clock_i, .write_clock_o(write_clock_i),
    .write_enable_n_o(write_enable_n_i), .data_o(data_in_i), .read_clock_o(read_clock_i),
    .read_enable_n_o(read_enable_n_i));

  initial begin
    forever #25 clock_i = ~clock_i;
  end

  task tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic er);
    int k;
    @(posedge clock_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_count++;
      $display("[FAIL] pready expected 1 seen %b", pready_o);
      tally_and_finish();
    end else begin
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask

  task flags();
    int c;
    logic [4:0] ev, got;
    c = q.size();
    got = {empty_flag_n_o, full_flag_n_o, almost_empty_flag_n_o, half_full_flag_n_o,
           almost_full_flag_n_o};
    if (ft) begin
      ev = {c == 0, c == dep + 1, c >= n + 2, c < dep / 2 + 2, c < dep + 1 - m};
    end else begin
      ev = {c > 0, c < dep, c >= n + 1, c < dep / 2 + 1, c < dep - m};
    end
    chk("flags", 32'(ev), 32'(got));
    apb(1'b0, `REG_LEVEL, 32'h0, r, e);
    chk("level", c, r);
  endtask

  task op(input logic wr);
    logic [17:0] d;
    d = 18'($random(seed)) & msk;
    if (wr) begin
      link_partner_inst.cyc(1'b1, 1'b0, d);
      if (q.size() < (ft ? dep + 1 : dep)) q.push_back(d);
    end else begin
      link_partner_inst.cyc(1'b0, 1'b1, 18'h00000);
      if (q.size() > 0) begin
        expd = q.pop_front();
        have = 1'b1;
      end
    end
    repeat (4) link_partner_inst.cyc(1'b0, 1'b0, 18'h00000);
    if (ft && q.size() > 0) begin
      expd = q[0];
      have = 1'b1;
    end
    if (have) chk("data_out", 32'(expd), 32'(data_out_o));
    flags();
  endtask

  initial begin
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    for (p = 0; p < 3; p++) begin
      ft = (p == 1);
      dep = (p == 2) ? 32 : 16;
      msk = (p == 2) ? 18'h001FF : 18'h3FFFF;
      q.delete();
      have = 1'b0;
      n = 2;
      m = 3;
      master_reset_n_i <= 1'b0;
      fallthrough_select_serial_in_i <= ft;
      flag_timing_select_i <= ft;
      narrow_ports_i <= (p == 2);
      {offset_load_n_i, offset_select_0_i, offset_select_1_i} <= pins[p];
      repeat (8) @(posedge clock_i);
      master_reset_n_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      apb(1'b0, `REG_EMPTY_OFFSET, 32'h0, r, e);
      chk("default offset", dflt[p], r);
      apb(1'b0, `REG_STATUS, 32'h0, r, e);
      chk("status", {29'h0, ft, ft, p == 2}, {29'h0, r[5], r[6], r[7]});
      // Upper bits must be ignored, only the low 19 hold the offset
      apb(1'b1, `REG_EMPTY_OFFSET, 32'hFFF80002, r, e);
      apb(1'b1, `REG_FULL_OFFSET, 32'h00000003, r, e);
      chk("write error", 32'h00000000, 32'(e));
      apb(1'b0, `REG_EMPTY_OFFSET, 32'h0, r, e);
      chk("empty offset", 32'h00000002, r);
      apb(1'b1, `REG_STATUS, 32'h0, r, e);
      chk("read-only write", 32'h00000001, 32'(e));
      apb(1'b0, 32'h00000040, 32'h0, r, e);
      chk("unmapped read", 32'h00000001, 32'(e));
      flags();
      repeat (dep + 2) op(1'b1);
      repeat (dep + 3) op(1'b0);
      repeat (24) op($random(seed) % 2 == 0);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
